/* File: src/gtc_pkg.sv */
package gtc_pkg;
  // ---------------------------------------------------------------
  // count layout
  // ---------------------------------------------------------------
  localparam int GTC_LOW_BITS = 5;
  localparam int GTC_HIGH_BITS = 8;
  localparam int GTC_CNT_BITS = GTC_LOW_BITS + GTC_HIGH_BITS;
  localparam logic [7:0] GTC_LOW_RESET = 8'h00;
  localparam logic [7:0] GTC_HIGH_RESET = 8'h00;
  // ---------------------------------------------------------------
  // prescale codes and divide ratios
  // ---------------------------------------------------------------
  localparam logic [1:0] GTC_PRE_DIV12 = 2'h0;
  localparam logic [1:0] GTC_PRE_DIV48 = 2'h2;
  localparam logic [1:0] GTC_PRE_EXT8 = 2'h3;
  localparam int GTC_SYS_DIV_A = 12;
  localparam int GTC_SYS_DIV_B = 48;
  localparam int GTC_EXT_DIV = 8;

  typedef struct packed {
    logic count_source_select;
    logic sysclk_select;
    logic run_control;
    logic gate_control;
    logic gate_polarity;
  } gtc_ctrl_s;

  typedef struct packed {
    logic load;
    logic [7:0] low;
    logic [7:0] high;
  } gtc_load_s;
endpackage : gtc_pkg

/* File: src/gtc_timer_pair.sv */
// How it works
// - counter mode counts falling edges on pin
// - fast select counts every system clock
// - otherwise counts the chosen prescaled tick
// - count only when run and gate allow
// - run bit never clears or preloads count
// - second timer built identically, own bits
// - second timer gated by second gate input
// - prescale codes 00/10/11 pick 12/48/ext8
// - irq only with enable and global enable
module gtc_timer_pair
  import gtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] clock_prescale_select_i,
  input wire logic external_oscillator_clock_i,
  input wire logic global_irq_enable_i,
  input wire logic overflow_irq_enable_a_i,
  input wire gtc_ctrl_s ctrl_a_i,
  input wire gtc_ctrl_s ctrl_b_i,
  input wire gtc_load_s load_a_i,
  input wire gtc_load_s load_b_i,
  input wire logic count_input_pin_a_i,
  input wire logic count_input_pin_b_i,
  input wire logic gate_input_a_i,
  input wire logic gate_input_b_i,
  input wire logic overflow_clear_a_i,
  input wire logic overflow_clear_b_i,
  output logic [7:0] count_low_a_o,
  output logic [7:0] count_high_a_o,
  output logic [7:0] count_low_b_o,
  output logic [7:0] count_high_b_o,
  output logic overflow_flag_a_o,
  output logic overflow_flag_b_o,
  output logic timer_a_irq_o
);
  // ---------------------------------------------------------------
  // shared prescaler
  // ---------------------------------------------------------------
  logic [5:0] sys_div_reg;
  logic [2:0] ext_div_reg;
  logic ext_sync1_reg;
  logic ext_sync2_reg;
  logic ext_prev_reg;
  logic ext_rise;
  logic tick12;
  logic tick48;
  logic tick_ext;
  logic pre_tick;
  logic [5:0] sys_div_next;
  logic sel_ext8;
  logic sel_div48;

  assign tick48 = (sys_div_reg == 6'(GTC_SYS_DIV_B - 1));
  // div-12 tick aligned within the div-48 frame
  assign tick12 = (sys_div_reg == 6'(GTC_SYS_DIV_A - 1)) || (sys_div_reg == 6'(2 * GTC_SYS_DIV_A - 1))
    || (sys_div_reg == 6'(3 * GTC_SYS_DIV_A - 1)) || tick48;
  assign sys_div_next = tick48 ? 6'h00 : sys_div_reg + 6'h01;
  assign ext_rise = ext_sync2_reg && !ext_prev_reg;
  assign tick_ext = ext_rise && (ext_div_reg == 3'(GTC_EXT_DIV - 1));
  // code 01 is undefined; it falls back to div 12
  assign sel_ext8 = (clock_prescale_select_i == GTC_PRE_EXT8);
  assign sel_div48 = (clock_prescale_select_i == GTC_PRE_DIV48);
  assign pre_tick = sel_ext8 ? tick_ext : (sel_div48 ? tick48 : tick12);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_div_reg <= 6'h00;
    end else begin
      sys_div_reg <= sys_div_next;
    end
  end

  // ---------------------------------------------------------------
  // external oscillator divider
  // ---------------------------------------------------------------
  // the oscillator is asynchronous: two flops before the edge detect
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_div_reg <= 3'h0;
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_sync1_reg <= external_oscillator_clock_i;
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg <= ext_sync2_reg;
      if (ext_rise) begin
        ext_div_reg <= ext_div_reg + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // the two timers
  // ---------------------------------------------------------------
  gtc_timer_unit #(
    .LOW_BITS(GTC_LOW_BITS)
  ) u_timer_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ctrl_i(ctrl_a_i),
    .load_i(load_a_i),
    .pre_tick_i(pre_tick),
    .count_pin_i(count_input_pin_a_i),
    .gate_input_i(gate_input_a_i),
    .overflow_clear_i(overflow_clear_a_i),
    .count_low_o(count_low_a_o),
    .count_high_o(count_high_a_o),
    .overflow_o(overflow_flag_a_o)
  );

  gtc_timer_unit #(
    .LOW_BITS(GTC_LOW_BITS)
  ) u_timer_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ctrl_i(ctrl_b_i),
    .load_i(load_b_i),
    .pre_tick_i(pre_tick),
    .count_pin_i(count_input_pin_b_i),
    .gate_input_i(gate_input_b_i),
    .overflow_clear_i(overflow_clear_b_i),
    .count_low_o(count_low_b_o),
    .count_high_o(count_high_b_o),
    .overflow_o(overflow_flag_b_o)
  );

  // ---------------------------------------------------------------
  // timer a interrupt request
  // ---------------------------------------------------------------
  // combinational, so the request drops in the cycle the flag clears
  assign timer_a_irq_o = overflow_flag_a_o && overflow_irq_enable_a_i && global_irq_enable_i;
endmodule : gtc_timer_pair

module gtc_timer_unit
  import gtc_pkg::*;
#(
  parameter int LOW_BITS = GTC_LOW_BITS
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gtc_ctrl_s ctrl_i,
  input wire gtc_load_s load_i,
  input wire logic pre_tick_i,
  input wire logic count_pin_i,
  input wire logic gate_input_i,
  input wire logic overflow_clear_i,
  output logic [7:0] count_low_o,
  output logic [7:0] count_high_o,
  output logic overflow_o
);
  logic [7:0] low_reg;
  logic [7:0] high_reg;
  logic ovf_reg;
  logic pin_prev_reg;
  logic pin_fall;
  logic tick;
  logic enable;
  logic advance;
  logic wrap;
  localparam int CNT_BITS = LOW_BITS + GTC_HIGH_BITS;
  logic gate_open;
  logic internal_tick;
  logic [CNT_BITS-1:0] cnt;
  logic [CNT_BITS-1:0] cnt_next;

  // ---------------------------------------------------------------
  // count source and enable
  // ---------------------------------------------------------------
  assign pin_fall = pin_prev_reg && !count_pin_i;
  assign internal_tick = ctrl_i.sysclk_select ? 1'b1 : pre_tick_i;
  assign tick = ctrl_i.count_source_select ? pin_fall : internal_tick;
  assign gate_open = !ctrl_i.gate_control || (gate_input_i == ctrl_i.gate_polarity);
  assign enable = ctrl_i.run_control && gate_open;
  assign advance = tick && enable;
  assign cnt = {high_reg, low_reg[LOW_BITS-1:0]};
  assign cnt_next = cnt + CNT_BITS'(1);
  assign wrap = advance && (cnt == {CNT_BITS{1'b1}});
  assign count_low_o = low_reg;
  assign count_high_o = high_reg;
  assign overflow_o = ovf_reg;

  // ---------------------------------------------------------------
  // count pin edge detect
  // ---------------------------------------------------------------
  // count pins are synchronous; reset high, so a pin that is low at release counts as a fall
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_prev_reg <= 1'b1;
    end else begin
      pin_prev_reg <= count_pin_i;
    end
  end

  // ---------------------------------------------------------------
  // count register
  // ---------------------------------------------------------------
  // run bit only gates counting; the count is never cleared by it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_reg <= GTC_LOW_RESET;
      high_reg <= GTC_HIGH_RESET;
    end else begin
      if (load_i.load) begin
        low_reg <= load_i.low;
        high_reg <= load_i.high;
      end else if (advance) begin
        // upper low bits are kept as stored
        low_reg <= {low_reg[7:LOW_BITS], cnt_next[LOW_BITS-1:0]};
        high_reg <= cnt_next[CNT_BITS-1:LOW_BITS];
      end
    end
  end

  // ---------------------------------------------------------------
  // overflow flag
  // ---------------------------------------------------------------
  // set wins over clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_reg <= 1'b0;
    end else if (wrap) begin
      ovf_reg <= 1'b1;
    end else if (overflow_clear_i) begin
      ovf_reg <= 1'b0;
    end
  end
endmodule : gtc_timer_unit

/* File: bench/gtc_chk.sv */
module gtc_chk import gtc_pkg::*; (
  input wire logic clk_i, rst_i, global_irq_enable_i, overflow_irq_enable_a_i, count_input_pin_a_i,
  input wire logic gate_input_b_i, overflow_flag_a_o, timer_a_irq_o,
  input wire gtc_ctrl_s ctrl_a_i, ctrl_b_i,
  input wire gtc_load_s load_a_i, load_b_i,
  input wire logic [7:0] count_low_a_o, count_high_a_o, count_low_b_o, count_high_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [12:0] ca = {count_high_a_o, count_low_a_o[4:0]};
  wire [12:0] cb = {count_high_b_o, count_low_b_o[4:0]};
  // fast ungated run with no load competing
  wire fa = ctrl_a_i[4:1] == 4'h6 && !load_a_i.load;
  sequence wrap_s; fa && ca == 13'h1fff; endsequence
  irq_and_a: assert property (timer_a_irq_o ==
    (overflow_flag_a_o && global_irq_enable_i && overflow_irq_enable_a_i)) else $error("irq");
  fast_step_a: assert property (fa |=> ca == $past(ca) + 13'h1) else $error("step");
  wrap_flag_a: assert property (wrap_s |=> overflow_flag_a_o && ca == 13'h0) else $error("wrap");
  stop_hold_a: assert property (!ctrl_a_i.run_control && !load_a_i.load |=> $stable(ca)) else $error("hold");
  gate_hold_b: assert property (ctrl_b_i.gate_control && gate_input_b_i != ctrl_b_i.gate_polarity
    && !load_b_i.load |=> $stable(cb)) else $error("gate");
  load_take_a: assert property (load_a_i.load |=> ca == $past({load_a_i.high, load_a_i.low[4:0]})) else $error("load");
  load_take_b: assert property (load_b_i.load |=> cb == $past({load_b_i.high, load_b_i.low[4:0]})) else $error("load");
  pin_fall_a: assert property (ctrl_a_i[4:1] == 4'ha && !load_a_i.load && $fell(count_input_pin_a_i)
    |=> ca == $past(ca) + 13'h1) else $error("pin");
endmodule : gtc_chk
bind gtc_timer_pair gtc_chk gtc_chk_i (.*);

/* File: bench/gtc_pins.sv */
module gtc_pins (input wire logic clk_i, output logic pin_a_o, output logic pin_b_o);
  timeunit 1ns; timeprecision 1ps;
  // idle high, so each low phase is one fall
  initial {pin_a_o, pin_b_o} = 2'h3;
  task automatic pulse(input int n, input logic [1:0] m);
    repeat (2 * n) @(posedge clk_i) {pin_a_o, pin_b_o} <= {pin_a_o, pin_b_o} ^ m;
  endtask : pulse
endmodule : gtc_pins

/* File: bench/testbench.sv */
module testbench import gtc_pkg::*; ;
  timeunit 1ns; timeprecision 1ps;
  logic clk_i = 1'h0, rst_i = 1'h1, ext = 1'h0, glb = 1'h0, ena = 1'h0, clr = 1'h0, ga = 1'h0, gb = 1'h1;
  logic pa, pb, fa, fb, irq;
  logic [1:0] pre = 2'h0;
  logic [7:0] al, ah, bl, bh;
  logic [12:0] lo[3] = '{13'h28, 13'ha, 13'hc};
  gtc_ctrl_s ca = '0, cb = '0;
  gtc_load_s lv = '0;
  int mismatches = 0, cmp_count = 0;
  wire [12:0] ta = {ah, al[4:0]}, tb = {bh, bl[4:0]};
  always #5 clk_i = ~clk_i;
  logic [2:0] ext_cnt = 3'h0;
  // oscillator stand-in, five clocks a period, edge-driven so the sync flops see no race
  always @(posedge clk_i) begin
    ext_cnt <= (ext_cnt == 3'h4) ? 3'h0 : ext_cnt + 3'h1;
    ext <= (ext_cnt < 3'h2);
  end
  gtc_pins gtc_pins_i (.clk_i, .pin_a_o(pa), .pin_b_o(pb));
  gtc_timer_pair gtc_timer_pair_i (.clk_i, .rst_i, .clock_prescale_select_i(pre), .external_oscillator_clock_i(ext),
    .global_irq_enable_i(glb), .overflow_irq_enable_a_i(ena), .ctrl_a_i(ca), .ctrl_b_i(cb), .load_a_i(lv),
    .load_b_i(lv), .count_input_pin_a_i(pa), .count_input_pin_b_i(pb), .gate_input_a_i(ga), .gate_input_b_i(gb),
    .overflow_clear_a_i(clr), .overflow_clear_b_i(clr), .count_low_a_o(al), .count_high_a_o(ah),
    .count_low_b_o(bl), .count_high_b_o(bh), .overflow_flag_a_o(fa), .overflow_flag_b_o(fb), .timer_a_irq_o(irq));
  task automatic chk(input logic [12:0] s, input logic [12:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic ld(input logic [12:0] v);
    // upper low bits loaded with 3'h5, so counting must be seen to leave them alone
    @(posedge clk_i) lv <= {1'h1, 3'h5, v[4:0], v[12:5]};
    @(posedge clk_i) lv.load <= 1'h0;
  endtask : ld
  task automatic run(input gtc_ctrl_s a, input gtc_ctrl_s b, input int n);
    @(posedge clk_i) {ca, cb} <= {a, b};
    repeat (n) @(posedge clk_i);
    {ca, cb} <= 10'h0;
    @(posedge clk_i) #1;
  endtask : run
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i) #1 chk({fa, fb, irq, ta[9:0]}, 13'h0);
    ld(13'h1fff);
    run(5'h0c, 5'h0c, 1);
    chk(ta | tb, 13'h0);
    chk({fa, fb}, 13'h3);
    @(posedge clk_i) {glb, ena} <= 2'h3;
    @(posedge clk_i) #1 chk(irq, 13'h1);
    @(posedge clk_i) clr <= 1'h1;
    @(posedge clk_i) clr <= 1'h0;
    #1 chk({fa, fb, irq}, 13'h0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i) pre <= i == 0 ? 2'h0 : 2'(i + 1);
      ld(13'h0);
      run(5'h04, 5'h04, 480);
      chk(ta, lo[i]);
    end
    chk({al[7:5], bl[7:5]}, 13'h2d);
    ld(13'h0);
    fork
      run(5'h14, 5'h14, 40);
      gtc_pins_i.pulse(5, 2'h3);
    join
    chk(ta, 13'h5);
    chk(tb, 13'h5);
    ld(13'h100);
    run(5'h0f, 5'h0e, 20);
    chk(ta, 13'h100);
    chk(tb, 13'h100);
    @(posedge clk_i) {ga, gb} <= 2'h2;
    run(5'h0f, 5'h0e, 20);
    chk(ta, 13'h114);
    chk(tb, 13'h114);
    close_out();
  end
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
endmodule : testbench
